// *** single_wire_slot_signaling.sv ***
// Purpose: Slave-side bit engine of a single-wire open-drain bus.
// Assumes: Pullup outside; line sampled through two flip-flops.
// Notes:   Bytes and commands are handled by logic on the user side.
`timescale 1ns/1ps
module single_wire_slot_signaling
  import single_wire_pkg::*;
#(
  parameter int CYC_PER_US_P = single_wire_pkg::CYC_PER_US
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Bus pin, open drain
  input  wire logic i_dq,
  output wire logic o_dq,
  output wire logic o_dq_oe,
  // Bits received in write slots
  output wire logic o_rx_valid,
  output wire logic o_rx_bit,
  input  wire logic i_rx_ready,
  output wire logic o_overrun,
  // Bits to send in read slots
  input  wire logic i_tx_valid,
  input  wire logic i_tx_bit,
  output wire logic o_tx_ready,
  // Operation status answer
  input  wire logic i_status_poll,
  input  wire logic i_op_busy,
  // Bus events
  output wire logic o_bus_reset,
  output wire logic o_presence
);
  import single_wire_pkg::*;

  localparam int PRE_W = (CYC_PER_US_P > 1) ? $clog2(CYC_PER_US_P) : 1;

  logic                dq_meta_ff;
  logic                dq_s_ff;
  logic                dq_d_ff;
  logic [PRE_W-1:0]    pre_ff;
  logic [US_W-1:0]     slot_us_ff;
  logic [US_W-1:0]     low_us_ff;
  slot_state_t         state_ff;
  slot_state_t         nxt_state;
  logic                rd_bit_ff;
  logic                bus_reset_ff;
  logic                overrun_ff;
  logic [16:0]         cyc_in_st_ff;
  wire                 tick;
  wire                 fall;
  wire                 st_chg;
  wire                 reset_seen;
  wire                 sample_go;
  wire                 start_read;

  bit_stream_if #(.W(1)) rx_in ();
  bit_stream_if #(.W(1)) rx_out ();

  // Pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dq_meta_ff <= 1'b1;
      dq_s_ff    <= 1'b1;
      dq_d_ff    <= 1'b1;
    end else begin
      dq_meta_ff <= i_dq;
      dq_s_ff    <= dq_meta_ff;
      dq_d_ff    <= dq_s_ff;
    end
  end

  assign fall   = dq_d_ff & ~dq_s_ff;
  assign st_chg = (nxt_state != state_ff);
  assign tick   = (pre_ff == PRE_W'(CYC_PER_US_P - 1));

  // Prescaler restarts with each state so intervals start on the edge.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_ff     <= '0;
      slot_us_ff <= '0;
    end else if (st_chg) begin
      pre_ff     <= '0;
      slot_us_ff <= '0;
    end else begin
      pre_ff <= tick ? '0 : pre_ff + 1'b1;
      if (tick && slot_us_ff != '1) slot_us_ff <= slot_us_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) low_us_ff <= '0;
    else if (dq_s_ff) low_us_ff <= '0;
    else if (tick && low_us_ff != RESET_DET_US) low_us_ff <= low_us_ff + 1'b1;
  end

  // A reset pulse is recognised in any state but ST_RST_LOW; it cancels the slot in flight.
  assign reset_seen = !dq_s_ff && (low_us_ff == RESET_DET_US) && (state_ff != ST_RST_LOW);
  assign start_read = (state_ff == ST_IDLE) && fall && (i_tx_valid || i_status_poll);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (fall) nxt_state = start_read ? ST_READ : ST_WRITE;
      end
      ST_WRITE: begin
        if (slot_us_ff >= WR_SAMPLE_US) nxt_state = ST_SLOT_END;
      end
      ST_READ: begin
        if (slot_us_ff >= RD_VALID_US) nxt_state = ST_SLOT_END;
      end
      ST_SLOT_END: begin
        if (dq_s_ff) nxt_state = ST_IDLE;
      end
      ST_RST_LOW: begin
        if (dq_s_ff) nxt_state = ST_PRES_WAIT;
      end
      ST_PRES_WAIT: begin
        if (slot_us_ff >= PRES_WAIT_US) nxt_state = ST_PRES_LOW;
      end
      ST_PRES_LOW: begin
        if (slot_us_ff >= PRES_LOW_US) nxt_state = ST_SLOT_END;
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (reset_seen) nxt_state = ST_RST_LOW;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) state_ff <= ST_IDLE;
    else state_ff <= nxt_state;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) rd_bit_ff <= 1'b1;
    else if (start_read) rd_bit_ff <= i_status_poll ? !i_op_busy : i_tx_bit;
  end

  assign o_tx_ready = start_read && !i_status_poll;

  assign sample_go  = (state_ff == ST_WRITE) && (nxt_state == ST_SLOT_END);
  assign rx_in.valid = sample_go & rx_in.ready;
  assign rx_in.data  = dq_s_ff;
  assign rx_out.ready = i_rx_ready;

  // A full buffer cannot stall the master, so the lost bit is flagged.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overrun_ff   <= 1'b0;
      bus_reset_ff <= 1'b0;
    end else begin
      overrun_ff   <= sample_go & ~rx_in.ready;
      bus_reset_ff <= (state_ff == ST_RST_LOW) && (nxt_state == ST_PRES_WAIT);
    end
  end

  two_entry_buf #(.W(1), .DEPTH(BUF_DEPTH)) u_rx_buf (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .s_in    (rx_in),
    .s_out   (rx_out)
  );

  assign o_dq_oe    = ((state_ff == ST_READ) && !rd_bit_ff) || (state_ff == ST_PRES_LOW);
  assign o_dq       = 1'b0;
  assign o_presence = (state_ff == ST_PRES_LOW);
  assign o_bus_reset = bus_reset_ff;
  assign o_overrun  = overrun_ff;
  assign o_rx_valid = rx_out.valid;
  assign o_rx_bit   = rx_out.data[0];

  // Cycles spent in the current state, read by the checks below.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) cyc_in_st_ff <= '0;
    else if (st_chg) cyc_in_st_ff <= '0;
    else if (cyc_in_st_ff != '1) cyc_in_st_ff <= cyc_in_st_ff + 1'b1;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_pres_wait_len: assert property (
    (state_ff == ST_PRES_WAIT && nxt_state == ST_PRES_LOW) |->
      (cyc_in_st_ff >= 17'(PRES_WAIT_MIN_US * CYC_PER_US_P)) &&
      (cyc_in_st_ff <= 17'(PRES_WAIT_MAX_US * CYC_PER_US_P)))
    else $error("presence delay out of range");
  a_pres_low_len: assert property (
    (state_ff == ST_PRES_LOW && nxt_state == ST_SLOT_END) |->
      (cyc_in_st_ff >= 17'(PRES_LOW_MIN_US * CYC_PER_US_P)) &&
      (cyc_in_st_ff <= 17'(PRES_LOW_MAX_US * CYC_PER_US_P)))
    else $error("presence pulse length out of range");
  a_reset_to_pres: assert property (
    (state_ff == ST_RST_LOW && dq_s_ff) |=> (state_ff == ST_PRES_WAIT) && o_bus_reset)
    else $error("reset pulse not followed by presence sequence");
  a_reset_detect: assert property (
    reset_seen |=> state_ff == ST_RST_LOW)
    else $error("long low not taken as reset");
  a_drive_in_slot: assert property (
    o_dq_oe |-> (state_ff == ST_READ || state_ff == ST_PRES_LOW))
    else $error("line driven outside read slot or presence");
  a_drive_after_edge: assert property (
    ($rose(o_dq_oe) && !o_presence) |-> $past(fall))
    else $error("data driven without a master falling edge");
  a_read_release: assert property (
    (state_ff == ST_READ) |-> cyc_in_st_ff < 17'(RD_HOLD_MAX_US * CYC_PER_US_P))
    else $error("read bit held too long");
  a_read_level: assert property (
    $rose(state_ff == ST_READ) |-> (o_dq_oe == !rd_bit_ff) [*4])
    else $error("read slot drive disagrees with bit");
  a_sample_window: assert property (
    sample_go |-> (cyc_in_st_ff >= 17'(SAMPLE_MIN_US * CYC_PER_US_P)) &&
      (cyc_in_st_ff <= 17'(SAMPLE_MAX_US * CYC_PER_US_P)))
    else $error("write slot sampled outside window");
  a_one_bit_slot: assert property (
    sample_go |=> state_ff == ST_SLOT_END && !sample_go)
    else $error("more than one bit taken in a slot");
  a_poll_answer: assert property (
    (start_read && i_status_poll) |=> rd_bit_ff == !$past(i_op_busy))
    else $error("poll answer does not match status");

  c_presence: cover property (state_ff == ST_PRES_WAIT && nxt_state == ST_PRES_LOW);
  c_write_slot: cover property (rx_in.valid && rx_in.ready);
  c_read_zero: cover property ((state_ff == ST_READ) && o_dq_oe);
  c_overrun: cover property (o_overrun);
endmodule

// *** single_wire_pkg.sv ***
// Purpose: Shared constants and types for the single-wire slot engine.
// Assumes: A 100 MHz system clock.
// Notes:   Bus times are held in microseconds; cycle counts derive from them.
package single_wire_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US     = 1000;
  localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
  localparam int US_W          = 10;
  localparam int BUF_DEPTH     = 2;

  // Bus timing in microseconds.
  localparam logic [US_W-1:0] RESET_LOW_MIN_US = 10'h1E0;
  // Reset is taken a little below the minimum pulse. A pulse of exactly the minimum
  // then still registers despite synchroniser delay and tick slip at state changes.
  localparam logic [US_W-1:0] RESET_DET_US     = 10'h1D6;
  localparam logic [US_W-1:0] PRES_WAIT_US     = 10'h01E;
  localparam logic [US_W-1:0] PRES_LOW_US      = 10'h078;
  localparam logic [US_W-1:0] WR_SAMPLE_US     = 10'h01E;
  localparam logic [US_W-1:0] RD_VALID_US      = 10'h00F;

  // Documented limits, used by the checks only.
  localparam int PRES_WAIT_MIN_US = 15;
  localparam int PRES_WAIT_MAX_US = 60;
  localparam int PRES_LOW_MIN_US  = 60;
  localparam int PRES_LOW_MAX_US  = 240;
  localparam int SAMPLE_MIN_US    = 15;
  localparam int SAMPLE_MAX_US    = 60;
  localparam int RD_HOLD_MAX_US   = 16;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_WRITE     = 3'b001,
    ST_READ      = 3'b010,
    ST_SLOT_END  = 3'b011,
    ST_RST_LOW   = 3'b100,
    ST_PRES_WAIT = 3'b101,
    ST_PRES_LOW  = 3'b110
  } slot_state_t;
endpackage

// *** bit_stream_if.sv ***
// Purpose: Valid/ready carrier between the slot engine and its buffer.
// Assumes: Both ends on the same clock.
// Notes:   A word moves on a cycle with valid and ready both high.
`timescale 1ns/1ps
interface bit_stream_if #(parameter int W = 1);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** two_entry_buf.sv ***
// Purpose: Small FIFO between the slot engine and the bit consumer.
// Assumes: DEPTH of at least two.
// Notes:   Output data comes straight from the storage flip-flops.
`timescale 1ns/1ps
module two_entry_buf #(
  parameter int W     = 1,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  // Streams
  bit_stream_if.snk   s_in,
  bit_stream_if.src   s_out
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [W-1:0]     mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] count_ff;
  wire              push;
  wire              pop;

  assign s_in.ready  = (count_ff != CNT_W'(DEPTH));
  assign s_out.valid = (count_ff != '0);
  assign s_out.data  = mem_ff[rd_ptr_ff];
  assign push        = s_in.valid & s_in.ready;
  assign pop         = s_out.valid & s_out.ready;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) wr_ptr_ff <= bump(wr_ptr_ff);
      if (pop) rd_ptr_ff <= bump(rd_ptr_ff);
      if (push && !pop) count_ff <= count_ff + 1'b1;
      else if (pop && !push) count_ff <= count_ff - 1'b1;
    end
  end

  // Storage needs no reset; entries are only read once written.
  always_ff @(posedge i_clk) begin
    if (push) mem_ff[wr_ptr_ff] <= s_in.data;
  end
endmodule

// *** single_wire_master_model.sv ***
// Purpose: Bus master model that opens every slot on the single-wire line.
// Assumes: Open-drain line with a pullup; o_pull high pulls the line low.
// Notes:   One microsecond is US clock cycles; every wait is bounded.
`timescale 1ns/1ps
module single_wire_master_model #(
  parameter int US = 2
) (
  // Clock
  input  wire logic i_clk,
  // Line
  input  wire logic i_line,
  output logic      o_pull
);
  import single_wire_pkg::*;

  initial o_pull = 1'b0;

  task automatic hold_us(input int n);
    repeat (n * US) @(posedge i_clk);
  endtask

  task automatic bus_reset(output int wait_cyc, output int low_cyc);
    wait_cyc = 0;
    low_cyc = 0;
    @(posedge i_clk);
    o_pull <= 1'b1;
    hold_us(int'(RESET_LOW_MIN_US));
    o_pull <= 1'b0;
    do begin
      @(posedge i_clk);
      wait_cyc++;
    end while (i_line !== 1'b0 && wait_cyc < 300 * US);
    do begin
      @(posedge i_clk);
      low_cyc++;
    end while (i_line === 1'b0 && low_cyc < 300 * US);
    hold_us(2);
  endtask

  // one early release, zero held whole slot.
  task automatic write_bit(input logic b);
    @(posedge i_clk);
    o_pull <= 1'b1;
    hold_us(b ? 5 : 60);
    o_pull <= 1'b0;
    hold_us(b ? 57 : 2);
  endtask

  // short low, sample late inside 15 us.
  task automatic read_bit(output logic b, output logic end_hi);
    @(posedge i_clk);
    o_pull <= 1'b1;
    hold_us(1);
    o_pull <= 1'b0;
    hold_us(12);
    b = i_line;
    hold_us(50);
    end_hi = i_line;
  endtask
endmodule

// *** single_wire_slot_signaling_tb.sv ***
// Purpose: Self-checking bench for the single-wire slave bit engine.
// Assumes: Tick divider of 2 cycles per microsecond to keep the run short.
// Notes:   The line is resolved here from both open-drain drivers.
`timescale 1ns/1ps
module single_wire_slot_signaling_tb;
  import single_wire_pkg::*;
  localparam int US = 2;
  logic       i_clk, i_rst_n, i_rx_ready, i_status_poll, i_op_busy, m_pull;
  wire logic  o_dq, o_dq_oe, o_rx_valid, o_rx_bit, o_overrun, o_tx_ready;
  wire logic  o_bus_reset, o_presence;
  int         miscompares = 0, n_tests = 0, n_ovr = 0, n_rst = 0, oe_cnt = 0;
  int         tx_left = 0;
  logic [7:0] tx_sr = 8'h00;
  logic       rxq[$];
  // A released line reads high through the pullup.
  wire logic  line = (o_dq_oe === 1'b1 ? o_dq : 1'b1) & ~m_pull;
  wire logic  tx_valid = (tx_left != 0);

  single_wire_slot_signaling #(.CYC_PER_US_P(US)) u_single_wire_slot_signaling (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_dq(line), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
    .o_rx_valid(o_rx_valid), .o_rx_bit(o_rx_bit), .i_rx_ready(i_rx_ready),
    .o_overrun(o_overrun), .i_tx_valid(tx_valid), .i_tx_bit(tx_sr[0]),
    .o_tx_ready(o_tx_ready), .i_status_poll(i_status_poll), .i_op_busy(i_op_busy),
    .o_bus_reset(o_bus_reset), .o_presence(o_presence));
  single_wire_master_model #(.US(US)) u_single_wire_master_model (
    .i_clk(i_clk), .i_line(line), .o_pull(m_pull));

  always @(posedge i_clk) begin
    if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1) rxq.push_back(o_rx_bit);
    if (o_overrun === 1'b1) n_ovr++;
    if (o_bus_reset === 1'b1) n_rst++;
    if (o_dq_oe === 1'b1) oe_cnt++;
    if (o_tx_ready === 1'b1) begin
      tx_sr <= tx_sr >> 1;
      tx_left <= tx_left - 1;
    end
  end

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("FAIL %0t: %s", $time, msg);
    end
  endtask

  task automatic t_reset;
    int w, l, r0, o0;
    r0 = n_rst;
    o0 = oe_cnt;
    u_single_wire_master_model.bus_reset(w, l);
    chk(w >= 15 * US && w <= 60 * US, "presence wait out of range");
    chk(l >= 60 * US && l <= 240 * US, "presence low out of range");
    chk(n_rst == r0 + 1 && oe_cnt > o0, "reset not answered");
    $display("test reset done");
  endtask

  task automatic t_write(input logic [7:0] v);
    logic [7:0] got;
    int o0;
    o0 = oe_cnt;
    @(posedge i_clk);
    i_rx_ready <= 1'b1;
    // The write slot opened by the reset pulse's falling edge leaves its sampled zero in the buffer; drain it first.
    repeat (4) @(posedge i_clk);
    rxq.delete();
    for (int i = 0; i < 8; i++) u_single_wire_master_model.write_bit(v[i]);
    repeat (4) @(posedge i_clk);
    got = 8'h00;
    foreach (rxq[i]) if (i < 8) got[i] = rxq[i];
    chk(rxq.size() == 8 && got === v, "write byte mismatch");
    chk(oe_cnt == o0, "device drove line in write slots");
    $display("test write done");
  endtask

  task automatic t_read(input logic [7:0] v);
    logic [7:0] got;
    logic       e;
    @(posedge i_clk);
    tx_sr <= v;
    tx_left <= 8;
    for (int i = 0; i < 8; i++) begin
      u_single_wire_master_model.read_bit(got[i], e);
      chk(e === 1'b1, "line not released at slot end");
    end
    chk(got === v, "read byte mismatch");
    chk(tx_left == 0 && o_rx_valid === 1'b0, "read slot bit count");
    $display("test read done");
  endtask

  task automatic t_poll;
    logic b, e;
    @(posedge i_clk);
    i_status_poll <= 1'b1;
    i_op_busy <= 1'b1;
    u_single_wire_master_model.read_bit(b, e);
    chk(b === 1'b0, "busy status not 0");
    i_op_busy <= 1'b0;
    u_single_wire_master_model.read_bit(b, e);
    chk(b === 1'b1, "done status not 1");
    i_status_poll <= 1'b0;
    $display("test poll done");
  endtask

  task automatic t_convert;
    int o0;
    t_write(8'h44);
    o0 = oe_cnt;
    // The line is held high while the conversion runs; the device must keep off it.
    repeat (200 * US) @(posedge i_clk);
    chk(oe_cnt == o0 && o_rx_valid === 1'b0, "device used line in conversion");
    $display("test convert done");
  endtask

  task automatic t_stall;
    logic b, e;
    int   n0;
    n0 = n_ovr;
    rxq.delete();
    @(posedge i_clk);
    i_rx_ready <= 1'b0;
    u_single_wire_master_model.write_bit(1'b1);
    u_single_wire_master_model.write_bit(1'b0);
    // With no word to send the slot is taken as a written one, which overflows.
    u_single_wire_master_model.read_bit(b, e);
    chk(b === 1'b1 && n_ovr == n0 + 1, "overrun not flagged");
    chk(o_rx_valid === 1'b1 && o_rx_bit === 1'b1, "stalled head wrong");
    i_rx_ready <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk(rxq.size() == 2 && rxq[0] === 1'b1 && rxq[1] === 1'b0, "drain order");
    $display("test stall done");
  endtask

  task automatic summarize;
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    i_rst_n = 1'b0;
    i_rx_ready = 1'b0;
    i_status_poll = 1'b0;
    i_op_busy = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_reset();
    t_write(8'hA5);
    t_write(8'h55);
    t_read(8'h5A);
    t_poll();
    t_convert();
    t_stall();
    t_reset();
    summarize();
  end

  initial begin
    repeat (100000) @(posedge i_clk);
    miscompares++;
    $display("FAIL %0t: run did not finish", $time);
    summarize();
  end
endmodule
